//--- src/bhlu_top.sv
// Summary of operation
// - Displacement sign-extended from 16 to 32 bits.
// - Base is zero when base field is zero.
// - Indexed form adds index register to base.
// - Byte load zero-extends into the target.
// - Halfword load sign-extends into the target.
// - Update forms write address into base register.
// - Set Rc bit leaves condition field undefined.
`timescale 1ns/1ps
`default_nettype none

module bhlu_top (
   // Clock, reset and enable
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Instruction issue
   input wire logic insn_valid_i,
   input wire logic [31:0] insn_i,
   output logic busy_o,
   // Register file read ports and values
   output logic [4:0] base_rd_addr_o,
   input wire logic [31:0] base_rd_data_i,
   output logic [4:0] idx_rd_addr_o,
   input wire logic [31:0] idx_rd_data_i,
   // Storage access path
   output logic mem_req_o,
   output logic [31:0] mem_addr_o,
   output logic mem_half_o,
   input wire logic mem_ack_i,
   input wire logic [15:0] mem_data_i,
   // Target register write
   output logic tgt_we_o,
   output logic [4:0] tgt_waddr_o,
   output logic [31:0] tgt_wdata_o,
   // Base register write for update forms
   output logic base_we_o,
   output logic [4:0] base_waddr_o,
   output logic [31:0] base_wdata_o,
   // Condition field zero may be clobbered
   output logic cond_undef_o
);

   typedef struct packed {
      bhlu_pkg::bhlu_state_type st;
      logic busy;
      logic [4:0] base_ra;
      logic [4:0] idx_ra;
      logic mem_req;
      logic [31:0] mem_addr;
      logic mem_half;
      logic is_update;
      logic is_indexed;
      logic [4:0] tgt;
      logic [4:0] base;
      logic cr_undef;
      logic tgt_we;
      logic [31:0] tgt_wdata;
      logic base_we;
      logic [31:0] base_wdata;
      logic cond_undef;
   } bhlu_regs_type;

   bhlu_regs_type state_r;
   bhlu_regs_type state_nxt;
   bhlu_dec_if dec ();

   // Address and data helpers used in several places.
   function automatic logic [31:0] bhlu_ea(input logic [4:0] base_f, input logic [31:0] base_v,
                                          input logic [31:0] offs);
      bhlu_ea = ((base_f == 5'h00) ? bhlu_pkg::WORD_RST : base_v) + offs;
   endfunction : bhlu_ea

   function automatic logic [31:0] bhlu_extend(input logic half, input logic [15:0] data);
      bhlu_extend = half ? {{16{data[15]}}, data} : {24'h00_0000, data[7:0]};
   endfunction : bhlu_extend

   bhlu_decode u_dec (
      .insn_i(insn_i),
      .insn_valid_i(insn_valid_i),
      .d(dec.dec)
   );

   // Indexed forms carry no displacement, so base plus index is formed in the first wait cycle.
   // Both read addresses are registered at issue, so the file answers from stable addresses.
   logic [31:0] idx_ea;
   assign idx_ea = bhlu_ea(state_r.base, base_rd_data_i, idx_rd_data_i);

   // Base and index are read one cycle after issue, giving the file a full cycle to answer.
   always_comb begin
      state_nxt = state_r;
      state_nxt.tgt_we = 1'b0;
      state_nxt.base_we = 1'b0;
      state_nxt.cond_undef = 1'b0;
      case (state_r.st)
         bhlu_pkg::BHLU_IDLE: begin
            if (dec.valid) begin
               state_nxt.st = bhlu_pkg::BHLU_WAIT;
               state_nxt.busy = 1'b1;
               state_nxt.base_ra = dec.base;
               state_nxt.idx_ra = dec.idx;
               state_nxt.mem_half = dec.is_half;
               state_nxt.is_update = dec.is_update;
               state_nxt.is_indexed = dec.is_indexed;
               state_nxt.tgt = dec.tgt;
               state_nxt.base = dec.base;
               state_nxt.cr_undef = dec.cr_undef;
               // Displacement kept in the address slot until the operands arrive.
               state_nxt.mem_addr = dec.disp;
               state_nxt.mem_req = 1'b0;
            end
         end
         bhlu_pkg::BHLU_WAIT: begin
            if (!state_r.mem_req) begin
               state_nxt.mem_addr = state_r.is_indexed ? idx_ea :
                  bhlu_ea(state_r.base, base_rd_data_i, state_r.mem_addr);
               state_nxt.mem_req = 1'b1;
            end else if (mem_ack_i) begin
               state_nxt.mem_req = 1'b0;
               state_nxt.st = bhlu_pkg::BHLU_DONE;
               state_nxt.tgt_we = 1'b1;
               state_nxt.tgt_wdata = bhlu_extend(state_r.mem_half, mem_data_i);
               state_nxt.base_we = state_r.is_update;
               state_nxt.base_wdata = state_r.mem_addr;
               state_nxt.cond_undef = state_r.cr_undef;
            end
         end
         bhlu_pkg::BHLU_DONE: begin
            state_nxt.st = bhlu_pkg::BHLU_IDLE;
            state_nxt.busy = 1'b0;
         end
         default: state_nxt.st = bhlu_pkg::BHLU_IDLE;
      endcase
   end

   // Register the whole state; a low enable freezes every field at once.
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         state_r <= '0;
         state_r.st <= bhlu_pkg::BHLU_IDLE;
      end else if (ce_i) begin
         state_r <= state_nxt;
      end
   end

   assign busy_o = state_r.busy;
   assign base_rd_addr_o = state_r.base_ra;
   assign idx_rd_addr_o = state_r.idx_ra;
   assign mem_req_o = state_r.mem_req;
   assign mem_addr_o = state_r.mem_addr;
   assign mem_half_o = state_r.mem_half;
   assign tgt_we_o = state_r.tgt_we;
   assign tgt_waddr_o = state_r.tgt;
   assign tgt_wdata_o = state_r.tgt_wdata;
   assign base_we_o = state_r.base_we;
   assign base_waddr_o = state_r.base;
   assign base_wdata_o = state_r.base_wdata;
   assign cond_undef_o = state_r.cond_undef;

endmodule : bhlu_top

`default_nettype wire

//--- src/bhlu_pkg.sv
package bhlu_pkg;

   // Instruction word fields, numbered from the least significant bit.
   localparam int TGT_MSB = 25;
   localparam int TGT_LSB = 21;
   localparam int BASE_MSB = 20;
   localparam int BASE_LSB = 16;
   localparam int IDX_MSB = 15;
   localparam int IDX_LSB = 11;
   localparam int DISP_MSB = 15;
   localparam int DISP_LSB = 0;
   localparam int XO_MSB = 10;
   localparam int XO_LSB = 1;
   localparam int OPC_MSB = 31;
   localparam int OPC_LSB = 26;
   localparam int RC_BIT = 0;

   // Primary opcodes of the displacement forms, and the one shared by the indexed forms.
   localparam logic [5:0] OPC_BYTE = 6'h22;
   localparam logic [5:0] OPC_BYTE_UPD = 6'h23;
   localparam logic [5:0] OPC_HALF_ALG = 6'h2a;
   localparam logic [5:0] OPC_HALF_ALG_UPD = 6'h2b;
   localparam logic [5:0] OPC_XFORM = 6'h1f;

   // Extended opcodes of the indexed forms.
   localparam logic [9:0] XO_BYTE_X = 10'h057;
   localparam logic [9:0] XO_BYTE_UX = 10'h077;
   localparam logic [9:0] XO_HALF_ALG_X = 10'h157;
   localparam logic [9:0] XO_HALF_ALG_UX = 10'h177;

   // Reset values.
   localparam logic [31:0] WORD_RST = 32'h0000_0000;
   localparam logic [4:0] REG_RST = 5'h00;

   typedef enum logic [1:0] {
      BHLU_IDLE,
      BHLU_WAIT,
      BHLU_DONE
   } bhlu_state_type;

endpackage : bhlu_pkg

//--- src/bhlu_dec_if.sv
`timescale 1ns/1ps
`default_nettype none

// Decoded load request handed from the decoder to the sequencer.
interface bhlu_dec_if;
   logic valid;
   logic is_half;
   logic is_update;
   logic is_indexed;
   logic cr_undef;
   logic [4:0] tgt;
   logic [4:0] base;
   logic [4:0] idx;
   logic [31:0] disp;

   modport dec (output valid, is_half, is_update, is_indexed, cr_undef, tgt, base, idx, disp);
   modport seq (input valid, is_half, is_update, is_indexed, cr_undef, tgt, base, idx, disp);
endinterface : bhlu_dec_if

`default_nettype wire

//--- src/bhlu_decode.sv
`timescale 1ns/1ps
`default_nettype none

// Combinational decoder of the four load forms for bytes and halfwords.
module bhlu_decode (
   // Instruction
   input wire logic [31:0] insn_i,
   input wire logic insn_valid_i,
   // Decoded request
   bhlu_dec_if.dec d
);

   logic [5:0] opc;
   logic [9:0] xo;
   logic is_x;

   assign opc = insn_i[bhlu_pkg::OPC_MSB:bhlu_pkg::OPC_LSB];
   assign xo = insn_i[bhlu_pkg::XO_MSB:bhlu_pkg::XO_LSB];
   assign is_x = (opc == bhlu_pkg::OPC_XFORM);

   // Recognise the opcode and classify the form.
   always_comb begin
      d.valid = 1'b0;
      d.is_half = 1'b0;
      d.is_update = 1'b0;
      d.is_indexed = is_x;
      if (insn_valid_i) begin
         case (opc)
            bhlu_pkg::OPC_BYTE: d.valid = 1'b1;
            bhlu_pkg::OPC_BYTE_UPD: begin
               d.valid = 1'b1;
               d.is_update = 1'b1;
            end
            bhlu_pkg::OPC_HALF_ALG: begin
               d.valid = 1'b1;
               d.is_half = 1'b1;
            end
            bhlu_pkg::OPC_HALF_ALG_UPD: begin
               d.valid = 1'b1;
               d.is_half = 1'b1;
               d.is_update = 1'b1;
            end
            bhlu_pkg::OPC_XFORM: begin
               d.valid = (xo == bhlu_pkg::XO_BYTE_X) || (xo == bhlu_pkg::XO_BYTE_UX)
                  || (xo == bhlu_pkg::XO_HALF_ALG_X) || (xo == bhlu_pkg::XO_HALF_ALG_UX);
               d.is_half = (xo == bhlu_pkg::XO_HALF_ALG_X) || (xo == bhlu_pkg::XO_HALF_ALG_UX);
               d.is_update = (xo == bhlu_pkg::XO_BYTE_UX) || (xo == bhlu_pkg::XO_HALF_ALG_UX);
            end
            default: d.valid = 1'b0;
         endcase
      end
   end

   // Register fields and the displacement.
   // Sign-extend displacement.
   assign d.disp = {{16{insn_i[bhlu_pkg::DISP_MSB]}}, insn_i[bhlu_pkg::DISP_MSB:bhlu_pkg::DISP_LSB]};
   assign d.tgt = insn_i[bhlu_pkg::TGT_MSB:bhlu_pkg::TGT_LSB];
   assign d.base = insn_i[bhlu_pkg::BASE_MSB:bhlu_pkg::BASE_LSB];
   assign d.idx = insn_i[bhlu_pkg::IDX_MSB:bhlu_pkg::IDX_LSB];
   assign d.cr_undef = is_x && insn_i[bhlu_pkg::RC_BIT];

endmodule : bhlu_decode

`default_nettype wire

//--- bench/bhlu_properties.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of the load unit; the register file is held steady during a load.
module bhlu_checker (
   // Clock, reset and issue
   input wire logic sys_clk_i, rst_i, ce_i, insn_valid_i, busy_o,
   input wire logic [31:0] insn_i,
   // Register reads and storage access
   input wire logic [4:0] base_rd_addr_o,
   input wire logic [31:0] base_rd_data_i, idx_rd_data_i, mem_addr_o,
   input wire logic mem_req_o, mem_half_o, mem_ack_i,
   input wire logic [15:0] mem_data_i,
   // Register writes
   input wire logic tgt_we_o, base_we_o, cond_undef_o,
   input wire logic [4:0] tgt_waddr_o, base_waddr_o,
   input wire logic [31:0] tgt_wdata_o, base_wdata_o
);
   logic [31:0] insn_q;
   logic [15:0] data_q;
   logic xf;
   logic [31:0] offs;
   // The instruction is visible only on the taking edge, so it is kept here.
   always_ff @(posedge sys_clk_i) begin
      data_q <= mem_data_i;
      if (rst_i) begin
         insn_q <= 32'h0000_0000;
      end else if (ce_i && insn_valid_i && !busy_o) begin
         insn_q <= insn_i;
      end
   end
   // Offset chosen by form: index register or widened displacement.
   assign xf = insn_q[31:26] == bhlu_pkg::OPC_XFORM;
   assign offs = xf ? idx_rd_data_i : {{16{insn_q[15]}}, insn_q[15:0]};
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   sequence s_start; $rose(mem_req_o); endsequence
   sequence s_ack; ce_i && mem_req_o && mem_ack_i; endsequence
   property p_disp; s_start ##0 (!xf && base_rd_addr_o != 5'h00) |->
      mem_addr_o == base_rd_data_i + offs; endproperty
   property p_zero; s_start ##0 (base_rd_addr_o == 5'h00) |-> mem_addr_o == offs; endproperty
   property p_idx; s_start ##0 (xf && base_rd_addr_o != 5'h00) |->
      mem_addr_o == base_rd_data_i + idx_rd_data_i; endproperty
   property p_byte; s_ack ##0 !mem_half_o |=> tgt_we_o && tgt_wdata_o == {24'h0, data_q[7:0]};
   endproperty
   property p_half; s_ack ##0 mem_half_o |=> tgt_we_o &&
      tgt_wdata_o == {{16{data_q[15]}}, data_q}; endproperty
   property p_size; s_start |-> mem_half_o == (xf ? insn_q[9] : insn_q[29]); endproperty
   property p_upd; tgt_we_o |-> base_we_o == (xf ? insn_q[6] : insn_q[26]) && (!base_we_o ||
      (base_wdata_o == $past(mem_addr_o) && base_waddr_o == insn_q[20:16])); endproperty
   property p_cond; tgt_we_o |->
      cond_undef_o == (xf && insn_q[0]) && tgt_waddr_o == insn_q[25:21]; endproperty
   a_disp: assert property (p_disp) else $error("displacement address wrong");
   a_zero: assert property (p_zero) else $error("zero base address wrong");
   a_idx: assert property (p_idx) else $error("indexed address wrong");
   a_byte: assert property (p_byte) else $error("byte result wrong");
   a_half: assert property (p_half) else $error("halfword result wrong");
   a_size: assert property (p_size) else $error("access size wrong");
   a_upd: assert property (p_upd) else $error("base update wrong");
   a_cond: assert property (p_cond) else $error("condition flag wrong");
endmodule : bhlu_checker
bind bhlu_top bhlu_checker u_chk (.*);
`default_nettype wire

//--- bench/bhlu_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// Storage path stand-in: acknowledges after a set number of cycles.
module bhlu_mem_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [3:0] lat_i,
   input wire logic req_i,
   input wire logic [31:0] addr_i,
   output logic ack_o,
   output logic [15:0] data_o
);
   logic [3:0] cnt_r;
   logic [15:0] last_r;
   // Outside the ack cycle the lines show the inverse of the last word, so stale data fails.
   assign data_o = ack_o ? (addr_i[15:0] ^ 16'h9c5a) : ~last_r;
   // Count the wait, then give a one-cycle acknowledge.
   always_ff @(posedge clk_i) begin
      if (rst_i || ack_o) begin
         ack_o <= 1'b0;
         cnt_r <= 4'h0;
         last_r <= rst_i ? 16'h0000 : data_o;
      end else if (req_i) begin
         ack_o <= cnt_r == lat_i;
         cnt_r <= cnt_r + 4'h1;
      end
   end
endmodule : bhlu_mem_model
`default_nettype wire

//--- bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic sys_clk_i, rst_i, ce_i, insn_valid_i, busy_o, mem_req_o, mem_half_o, mem_ack_i;
   logic tgt_we_o, base_we_o, cond_undef_o;
   logic [3:0] mem_lat;
   logic [4:0] base_rd_addr_o, idx_rd_addr_o, tgt_waddr_o, base_waddr_o;
   logic [31:0] insn_i, base_rd_data_i, idx_rd_data_i, mem_addr_o, tgt_wdata_o, base_wdata_o;
   logic [15:0] mem_data_i;
   int num_errors = 0;
   int comparisons = 0;
   // Register contents are a fixed function of the index, so loads stand alone.
   function automatic logic [31:0] rfv(input logic [4:0] a);
      return {11'h000, a, 16'h8123};
   endfunction : rfv
   assign base_rd_data_i = rfv(base_rd_addr_o);
   assign idx_rd_data_i = rfv(idx_rd_addr_o);
   bhlu_top u_dut (.*);
   bhlu_mem_model u_mem (.clk_i(sys_clk_i), .rst_i(rst_i), .lat_i(mem_lat), .req_i(mem_req_o),
      .addr_i(mem_addr_o), .ack_o(mem_ack_i), .data_o(mem_data_i));
   initial begin
      sys_clk_i = 1'b0;
      forever #10 sys_clk_i = ~sys_clk_i;
   end
   task complete_run;
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : complete_run
   task chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   function automatic logic [31:0] mk_d(input logic [5:0] o, input logic [4:0] t, a,
      input logic [15:0] d);
      return {o, t, a, d};
   endfunction : mk_d
   function automatic logic [31:0] mk_x(input logic [9:0] xo, input logic [4:0] t, a, b,
      input logic rc);
      return {bhlu_pkg::OPC_XFORM, t, a, b, xo, rc};
   endfunction : mk_x
   // Issue one load, follow it to its write-back and judge every result.
   task run_load(input logic [31:0] insn, input logic [3:0] lat);
      logic x, half, upd;
      logic [31:0] ea, seen;
      logic [15:0] d;
      int n;
      x = insn[31:26] === bhlu_pkg::OPC_XFORM;
      half = x ? insn[9] : insn[29];
      upd = x ? insn[6] : insn[26];
      ea = (insn[20:16] == 5'h00 ? 32'h0 : rfv(insn[20:16]))
         + (x ? rfv(insn[15:11]) : {{16{insn[15]}}, insn[15:0]});
      d = ea[15:0] ^ 16'h9c5a;
      seen = 32'h0;
      n = 0;
      @(posedge sys_clk_i);
      insn_i <= insn;
      insn_valid_i <= 1'b1;
      mem_lat <= lat;
      @(posedge sys_clk_i);
      insn_valid_i <= 1'b0;
      do begin
         @(posedge sys_clk_i);
         #1;
         if (mem_req_o === 1'b1) seen = mem_addr_o;
         n++;
      end while (tgt_we_o !== 1'b1 && n < 60);
      chk(tgt_wdata_o, half ? {{16{d[15]}}, d} : {24'h0, d[7:0]});
      chk(seen, ea);
      chk({cond_undef_o, base_we_o, tgt_waddr_o}, {x & insn[0], upd, insn[25:21]});
      if (upd) chk(base_wdata_o, ea);
      if (upd) chk({27'h0, base_waddr_o}, {27'h0, insn[20:16]});
      while (busy_o !== 1'b0 && n < 70) begin
         @(posedge sys_clk_i);
         #1;
         n++;
      end
      // A load that never finishes counts as a mismatch and ends the run.
      if (n >= 60) begin
         num_errors++;
         complete_run();
      end
   endtask : run_load
   // Both signs of displacement, with update forms on legal base fields.
   task test_displacement;
      run_load(mk_d(bhlu_pkg::OPC_BYTE, 5'h04, 5'h03, 16'hfff0), 4'h1);
      run_load(mk_d(bhlu_pkg::OPC_HALF_ALG_UPD, 5'h06, 5'h05, 16'h7ffe), 4'h3);
      run_load(mk_d(bhlu_pkg::OPC_BYTE_UPD, 5'h07, 5'h02, 16'h8000), 4'h0);
   endtask : test_displacement
   // Zero base field with data of both signs and a byte whose top bit is set.
   task test_sign;
      run_load(mk_d(bhlu_pkg::OPC_HALF_ALG, 5'h09, 5'h00, 16'h0002), 4'h2);
      run_load(mk_d(bhlu_pkg::OPC_HALF_ALG, 5'h0a, 5'h00, 16'h8000), 4'h0);
      run_load(mk_d(bhlu_pkg::OPC_BYTE, 5'h0b, 5'h00, 16'h0080), 4'h5);
      run_load(mk_x(bhlu_pkg::XO_BYTE_X, 5'h0c, 5'h00, 5'h1f, 1'b1), 4'h1);
   endtask : test_sign
   // Every indexed form, flag bit alternating, slow and quick storage.
   task test_indexed;
      logic [9:0] tab [4];
      tab = '{bhlu_pkg::XO_BYTE_X, bhlu_pkg::XO_BYTE_UX, bhlu_pkg::XO_HALF_ALG_X,
         bhlu_pkg::XO_HALF_ALG_UX};
      for (int i = 0; i < 4; i++) begin
         run_load(mk_x(tab[i], 5'(i + 8), 5'h0d, 5'h1d, i[0]), 4'(i * 3));
      end
   endtask : test_indexed
   // Reset for two cycles, then run the scenarios back to back.
   initial begin
      rst_i = 1'b1;
      ce_i = 1'b1;
      insn_valid_i = 1'b0;
      insn_i = 32'h0000_0000;
      mem_lat = 4'h0;
      repeat (2) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      test_displacement();
      test_sign();
      test_indexed();
      complete_run();
   end
endmodule : testbench
`default_nettype wire
